//--- rtl/cta_core.sv
// Conversion trigger, channel sequencing, overcurrent latch and strap decode.
// Assumes an ADC core on clk_i that answers adc_start_o with adc_done_i.
//
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps

module cta_core
	import cta_pkg::*;
#(
	parameter int DW = ADC_W
)(
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          low_supply_lockout_i,
	input  wire logic          conversion_trigger_pin_i,
	input  wire logic          analog_threshold_input_i,
	input  wire logic [2:0]    addr_strap_low_i,
	input  wire logic [2:0]    addr_strap_high_i,
	input  wire logic          adc_done_i,
	input  wire logic [DW-1:0] adc_data_i,
	output logic               adc_start_o,
	output logic               adc_chan_o,
	output logic               overcurrent_flag_n_o,
	output logic               overcurrent_flag_oe_o,
	output logic [6:0]         slave_addr_o,
	output logic               irq_o,
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	input  wire logic          wb_we_i,
	input  wire logic [7:0]    wb_adr_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic [31:0]   wb_dat_i,
	output logic [31:0]        wb_dat_o,
	output logic               wb_ack_o
);

	// ==========================================================
	// Pin synchronisers
	logic [8:0] s1_q;
	logic [8:0] s2_q;
	logic [8:0] pins;
	logic       lock_s;
	logic       trig_s;
	logic       ana_s;
	logic [2:0] strap_lo_s;
	logic [2:0] strap_hi_s;
	logic       srst;

	assign pins = {addr_strap_high_i, addr_strap_low_i, analog_threshold_input_i,
		conversion_trigger_pin_i, low_supply_lockout_i};

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s1_q <= '0;
			s2_q <= '0;
		end
		else
		begin
			s1_q <= pins;
			s2_q <= s1_q;
		end
	end

	assign lock_s     = s2_q[0];
	assign trig_s     = s2_q[1];
	assign ana_s      = s2_q[2];
	assign strap_lo_s = s2_q[5:3];
	assign strap_hi_s = s2_q[8:6];
	assign srst       = rst_i | lock_s;

	// ==========================================================
	// State
	cta_state_t    st_q, st_d;
	logic [1:0]    conversion_trigger_pin_q, conversion_trigger_pin_d;
	logic          src_q, src_d;
	logic [DW-1:0] th_q, th_d;
	logic [DW-1:0] cur_q, cur_d;
	logic [DW-1:0] volt_q, volt_d;
	logic [IRQ_W-1:0] irq_q, irq_d;
	logic [IRQ_W-1:0] mask_q, mask_d;
	logic          int_q, int_d;
	logic          latch_q, latch_d;
	logic          flag_n_q, flag_n_d;
	logic          oe_q, oe_d;
	logic          start_q, start_d;
	logic          chan_q, chan_d;
	logic          ack_q, ack_d;
	logic [31:0]   dat_q, dat_d;
	logic [6:0]    addr_q, addr_d;
	logic          addr_ok_q, addr_ok_d;
	logic [3:0]    settle_q, settle_d;
	logic          req;
	logic          wr;
	logic          clr_wr;
	logic          over;
	logic [31:0]   rd;
	logic [31:0]   m;

	assign req    = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr     = wb_cyc_i & wb_stb_i & wb_we_i & ack_q; // Commit at the acknowledging edge
	assign clr_wr = wr && wb_adr_i == REG_ALERT_CTRL && wb_sel_i[0] && wb_dat_i[AC_CLR];
	assign over   = src_q ? (cur_q > th_q) : ana_s;

	// ==========================================================
	// Next state
	always_comb
	begin
		st_d      = st_q;
		conversion_trigger_pin_d    = conversion_trigger_pin_q;
		src_d     = src_q;
		th_d      = th_q;
		cur_d     = cur_q;
		volt_d    = volt_q;
		irq_d     = irq_q;
		mask_d    = mask_q;
		latch_d   = latch_q;
		start_d   = 1'b0;
		chan_d    = chan_q;
		ack_d     = req;
		dat_d     = '0;
		addr_d    = addr_q;
		addr_ok_d = addr_ok_q;
		settle_d  = settle_q;
		rd        = '0;
		m         = '0;

		// Register read
		if (wb_adr_i == REG_CONVERSION_TRIGGER_PIN_CTRL)
			rd[1:0] = conversion_trigger_pin_q;
		else if (wb_adr_i == REG_ALERT_CTRL)
			rd[AC_SRC] = src_q;
		else if (wb_adr_i == REG_ALERT_THRESHOLD_REG)
			rd[DW-1:0] = th_q;
		else if (wb_adr_i == REG_STATUS)
		begin
			rd[STS_LATCH] = latch_q;
			rd[STS_BUSY]  = st_q != CTA_IDLE;
			rd[STS_CMP]   = over;
			rd[STS_ADDR_LO +: 7] = addr_q;
		end
		else if (wb_adr_i == REG_CURRENT)
			rd[DW-1:0] = cur_q;
		else if (wb_adr_i == REG_VOLTAGE)
			rd[DW-1:0] = volt_q;
		else if (wb_adr_i == REG_IRQ_STAT)
			rd[IRQ_W-1:0] = irq_q;
		else if (wb_adr_i == REG_IRQ_MASK)
			rd[IRQ_W-1:0] = mask_q;
		if (req && !wb_we_i)
			dat_d = rd;

		// Register write, unmapped offsets ignored
		m = cta_merge(rd, wb_dat_i, wb_sel_i);
		if (wr)
		begin
			if (wb_adr_i == REG_CONVERSION_TRIGGER_PIN_CTRL)
				conversion_trigger_pin_d = m[1:0];
			else if (wb_adr_i == REG_ALERT_CTRL)
				src_d = m[AC_SRC];
			else if (wb_adr_i == REG_ALERT_THRESHOLD_REG)
				th_d = m[DW-1:0];
			else if (wb_adr_i == REG_IRQ_MASK)
				mask_d = m[IRQ_W-1:0];
		end
		if (req && !wb_we_i && wb_adr_i == REG_IRQ_STAT)
			irq_d = '0;

		// Conversion sequencer
		case (st_q)
			CTA_IDLE:
			begin
				if (trig_s && conversion_trigger_pin_q != 2'h0)
				begin
					start_d = 1'b1;
					if (conversion_trigger_pin_q[CC_CUR])
					begin
						chan_d = CH_CUR;
						st_d   = CTA_CUR;
					end
					else
					begin
						chan_d = CH_VOLT;
						st_d   = CTA_VOLT;
					end
				end
			end
			CTA_CUR:
			begin
				if (adc_done_i)
				begin
					cur_d = adc_data_i;
					irq_d[IRQ_CUR] = 1'b1;
					if (conversion_trigger_pin_q[CC_VOLT])
					begin
						start_d = 1'b1;
						chan_d  = CH_VOLT;
						st_d    = CTA_VOLT;
					end
					else
						st_d = CTA_IDLE;
				end
			end
			CTA_VOLT:
			begin
				if (adc_done_i)
				begin
					volt_d = adc_data_i;
					irq_d[IRQ_VOLT] = 1'b1;
					st_d = CTA_IDLE;
				end
			end
			default:
				st_d = CTA_IDLE;
		endcase

		// Overcurrent latch, a set beats a clear
		if (clr_wr)
			latch_d = 1'b0;
		if (over)
			latch_d = 1'b1;
		if (over && !latch_q)
			irq_d[IRQ_ALERT] = 1'b1;

		flag_n_d = ~latch_d;
		oe_d     = latch_d;
		int_d    = |(irq_d & mask_d);

		// Strap capture once the synchronisers settle
		if (!addr_ok_q)
		begin
			settle_d = settle_q + 4'h1;
			if (settle_q == SETTLE_CNT)
			begin
				addr_d    = {ADDR_BASE, cta_strap(strap_hi_s), cta_strap(strap_lo_s)};
				addr_ok_d = 1'b1;
			end
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk_i)
	begin
		if (srst)
		begin
			st_q      <= CTA_IDLE;
			conversion_trigger_pin_q    <= CONVERSION_TRIGGER_PIN_RST;
			src_q     <= SRC_RST;
			th_q      <= TH_RST;
			cur_q     <= '0;
			volt_q    <= '0;
			irq_q     <= '0;
			mask_q    <= MASK_RST;
			int_q     <= 1'b0;
			latch_q   <= 1'b0;
			flag_n_q  <= 1'b1;
			oe_q      <= 1'b0;
			start_q   <= 1'b0;
			chan_q    <= CH_CUR;
			ack_q     <= 1'b0;
			dat_q     <= '0;
			addr_q    <= '0;
			addr_ok_q <= 1'b0;
			settle_q  <= '0;
		end
		else
		begin
			st_q      <= st_d;
			conversion_trigger_pin_q    <= conversion_trigger_pin_d;
			src_q     <= src_d;
			th_q      <= th_d;
			cur_q     <= cur_d;
			volt_q    <= volt_d;
			irq_q     <= irq_d;
			mask_q    <= mask_d;
			int_q     <= int_d;
			latch_q   <= latch_d;
			flag_n_q  <= flag_n_d;
			oe_q      <= oe_d;
			start_q   <= start_d;
			chan_q    <= chan_d;
			ack_q     <= ack_d;
			dat_q     <= dat_d;
			addr_q    <= addr_d;
			addr_ok_q <= addr_ok_d;
			settle_q  <= settle_d;
		end
	end

	assign adc_start_o           = start_q;
	assign adc_chan_o            = chan_q;
	assign overcurrent_flag_n_o  = flag_n_q;
	assign overcurrent_flag_oe_o = oe_q;
	assign slave_addr_o          = addr_q;
	assign irq_o                 = int_q;
	assign wb_dat_o              = dat_q;
	assign wb_ack_o              = ack_q;

	// ==========================================================
	// Assertions
	a_trig_start: assert property (@(posedge clk_i) disable iff (srst)
		(st_q == CTA_IDLE && trig_s && conversion_trigger_pin_q != 2'h0) |=> adc_start_o)
		else $error("trigger did not start a conversion");
	a_chan_volt: assert property (@(posedge clk_i) disable iff (srst)
		(st_q == CTA_IDLE && trig_s && conversion_trigger_pin_q == 2'h2) |=> (adc_chan_o == CH_VOLT))
		else $error("voltage-only select converted the wrong channel");
	a_no_trig: assert property (@(posedge clk_i) disable iff (srst)
		(st_q == CTA_IDLE && !trig_s) |=> !adc_start_o)
		else $error("conversion started without trigger");
	a_lock_reset: assert property (@(posedge clk_i)
		lock_s |=> (st_q == CTA_IDLE && !latch_q && !adc_start_o))
		else $error("lockout did not hold reset state");
	a_flag_drive: assert property (@(posedge clk_i) disable iff (srst)
		overcurrent_flag_oe_o == latch_q && overcurrent_flag_n_o == !latch_q)
		else $error("flag pin not following latch");
	a_digital_src: assert property (@(posedge clk_i) disable iff (srst)
		(src_q && cur_q > th_q) |=> latch_q)
		else $error("digital threshold did not set latch");
	a_latch_hold: assert property (@(posedge clk_i) disable iff (srst)
		(latch_q && !clr_wr) |=> latch_q)
		else $error("latch dropped without clear");
	a_latch_set: assert property (@(posedge clk_i) disable iff (srst)
		(over && !latch_q) |=> (latch_q && !overcurrent_flag_n_o))
		else $error("latch not set on first overcurrent cycle");
	a_addr_base: assert property (@(posedge clk_i) disable iff (srst)
		addr_ok_q |-> (slave_addr_o[6:4] == ADDR_BASE))
		else $error("slave address base bits wrong");
	a_addr_stable: assert property (@(posedge clk_i) disable iff (srst)
		(addr_ok_q && $past(addr_ok_q)) |-> $stable(slave_addr_o))
		else $error("slave address changed after capture");
	a_result_hold: assert property (@(posedge clk_i) disable iff (srst)
		(st_q == CTA_CUR && adc_done_i) |=> (cur_q == $past(adc_data_i)))
		else $error("current result not stored");
	a_ack_pulse: assert property (@(posedge clk_i) disable iff (srst)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held over two cycles");
endmodule // cta_core

//--- rtl/cta_pkg.sv
// Constants, types and helpers of the conversion trigger and alert latch.
// Assumes a 32-bit classic Wishbone slave port and a 200 MHz clock.
//
// Behaviour
// - A high level on the sampled trigger pin starts an ADC conversion.
// - A trigger converts current only, voltage only, both or neither, per the channel-select setting.
// - Conversions keep running while the trigger pin stays high; tie it high if unused.
// - A low-supply lockout holds the block in reset, restarting from reset when it clears.
// - The overcurrent flag is active low, open drain, pulling low while overcurrent is flagged.
// - Overcurrent is judged by the analog comparator or the threshold register, as selected.
// - Once asserted the flag stays latched low until software clears it via alert control.
// - Each address strap decodes to one of four states, giving sixteen slave addresses.
// - The seven-bit slave address has upper bits 011 and lower bits from the straps.

package cta_pkg;

	// ==========================================================
	// Register map (byte offsets)
	localparam logic [7:0] REG_CONVERSION_TRIGGER_PIN_CTRL  = 8'h00;
	localparam logic [7:0] REG_ALERT_CTRL = 8'h04;
	localparam logic [7:0] REG_ALERT_THRESHOLD_REG   = 8'h08;
	localparam logic [7:0] REG_STATUS     = 8'h0C;
	localparam logic [7:0] REG_CURRENT    = 8'h10;
	localparam logic [7:0] REG_VOLTAGE    = 8'h14;
	localparam logic [7:0] REG_IRQ_STAT   = 8'h18;
	localparam logic [7:0] REG_IRQ_MASK   = 8'h1C;

	// ==========================================================
	// Field positions and reset values
	localparam int         CC_CUR      = 0;
	localparam int         CC_VOLT     = 1;
	localparam int         AC_SRC      = 0;
	localparam int         AC_CLR      = 1;
	localparam int         STS_LATCH   = 0;
	localparam int         STS_BUSY    = 1;
	localparam int         STS_CMP     = 2;
	localparam int         STS_ADDR_LO = 8;
	localparam int         IRQ_CUR     = 0;
	localparam int         IRQ_VOLT    = 1;
	localparam int         IRQ_ALERT   = 2;
	localparam int         IRQ_W       = 3;
	localparam int         ADC_W       = 12;
	localparam logic [1:0] CONVERSION_TRIGGER_PIN_RST    = 2'h3;
	localparam logic       SRC_RST     = 1'h0;
	localparam logic [11:0] TH_RST     = 12'hFFF;
	localparam logic [2:0] MASK_RST    = 3'h0;
	localparam logic       CH_CUR      = 1'h0;
	localparam logic       CH_VOLT     = 1'h1;

	// ==========================================================
	// Address straps
	localparam logic [2:0] ADDR_BASE   = 3'h3;
	localparam int         SP_LOW      = 0;
	localparam int         SP_HIGH     = 1;
	localparam int         SP_FLOAT    = 2;
	localparam logic [1:0] ST_GND      = 2'h0;
	localparam logic [1:0] ST_RES      = 2'h1;
	localparam logic [1:0] ST_OPEN     = 2'h2;
	localparam logic [1:0] ST_VDD      = 2'h3;
	localparam logic [3:0] SETTLE_CNT  = 4'h8;

	typedef enum logic [1:0] {CTA_IDLE, CTA_CUR, CTA_VOLT} cta_state_t;

	// Sense bits {float, above high, above low} to a strap state
	function automatic logic [1:0] cta_strap(input logic [2:0] s);
		if (s[SP_FLOAT])
			return ST_OPEN;
		else if (s[SP_HIGH])
			return ST_VDD;
		else if (s[SP_LOW])
			return ST_RES;
		else
			return ST_GND;
	endfunction

	// Byte-lane merge of a Wishbone write
	function automatic logic [31:0] cta_merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] sel);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[i*8 +: 8] = n[i*8 +: 8];
		return r;
	endfunction

endpackage

//--- testbench/cta_adc_model.sv
// ADC core stand-in: answers each start with one done pulse after lat_i cycles.
// Assumes the block's clock and reset; the bench picks the result of each channel.
`timescale 1ns/1ps

module cta_adc_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  lat_i,
	input  wire logic        start_i,
	input  wire logic        chan_i,
	input  wire logic [11:0] cur_i,
	input  wire logic [11:0] volt_i,
	output logic             done_o,
	output logic [11:0]      data_o
);
	int cnt = 0;

	initial
	begin
		done_o = 1'b0;
		data_o = 12'h5A5;
	end

	always @(posedge clk_i)
	begin
		done_o <= 1'b0;
		// Result bus toggles outside the done cycle so a stale value is never seen
		data_o <= ~data_o;
		if (rst_i)
			cnt <= 0;
		else if (start_i)
			cnt <= lat_i;
		else if (cnt == 1)
		begin
			done_o <= 1'b1;
			data_o <= chan_i ? volt_i : cur_i;
			cnt <= 0;
		end
		else if (cnt > 0)
			cnt <= cnt - 1;
	end
endmodule // cta_adc_model

//--- testbench/conversion_trigger_and_alert_latch_tb_top.sv
// Bench for the conversion trigger and alert latch, driven over Wishbone.
// Assumes the ADC stand-in model and a pulled-up alert pin.
`timescale 1ns/1ps

module conversion_trigger_and_alert_latch_tb_top
	import cta_pkg::*;
;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        lock, trig, ana, cyc, stb, we, ack, irq;
	logic        adc_start, adc_chan, adc_done, flag_n, flag_oe;
	logic [1:0]  m;
	logic [2:0]  s_lo, s_hi;
	logic [6:0]  saddr;
	logic [7:0]  adr, lat;
	logic [11:0] cur_v, volt_v, adc_data, exp_cur, exp_volt;
	logic [31:0] wdat, rdat, dat_o;
	logic [2:0]  sns [4] = '{3'h0, 3'h1, 3'h4, 3'h2};
	logic [1:0]  modes [4] = '{2'h3, 2'h0, 2'h2, 2'h1};
	int          miscompares = 0;
	int          n_tests = 0;
	int          n_starts = 0;
	int          cycles = 0;
	int          n0;
	// Open-drain pin with its pull-up
	wire         alert_pin = flag_oe ? flag_n : 1'b1;

	cta_core u_cta_core (
		.clk_i(clk_i), .rst_i(rst_i), .low_supply_lockout_i(lock),
		.conversion_trigger_pin_i(trig), .analog_threshold_input_i(ana),
		.addr_strap_low_i(s_lo), .addr_strap_high_i(s_hi),
		.adc_done_i(adc_done), .adc_data_i(adc_data), .adc_start_o(adc_start),
		.adc_chan_o(adc_chan), .overcurrent_flag_n_o(flag_n),
		.overcurrent_flag_oe_o(flag_oe), .slave_addr_o(saddr), .irq_o(irq),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack));

	cta_adc_model u_cta_adc_model (
		.clk_i(clk_i), .rst_i(rst_i), .lat_i(lat), .start_i(adc_start),
		.chan_i(adc_chan), .cur_i(cur_v), .volt_i(volt_v),
		.done_o(adc_done), .data_o(adc_data));

	initial
	begin
		forever
			#2.5 clk_i = ~clk_i;
	end

	always @(posedge clk_i)
	begin
		if (adc_start === 1'b1)
			n_starts++;
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			summarize();
		end
	end

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
			@(posedge clk_i);
		while (ack !== 1'b1);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(nm, rdat, e);
	endtask

	task automatic tick(input int n);
		repeat (n)
			@(posedge clk_i);
	endtask

	// Wait for a start, then poll until the sequencer is idle
	task automatic idle_wait();
		repeat (40)
			if (adc_start !== 1'b1)
				@(posedge clk_i);
		rdat = 32'h2;
		repeat (60)
			if (rdat[STS_BUSY] !== 1'b0)
				wb(1'b0, REG_STATUS, 32'h0);
	endtask

	initial
	begin
		{lock, trig, ana, cyc, stb, we} = 6'h0;
		adr = 8'h0;
		wdat = 32'h0;
		lat = 8'h2;
		cur_v = 12'h0;
		volt_v = 12'h0;
		s_lo = sns[1];
		s_hi = sns[3];
		tick(12);
		rst_i <= 1'b0;
		tick(12);
		chk("flag_pin", alert_pin, 32'h1);
		chk("slave_addr", saddr, 32'h3D);
		rd("conversion_trigger_pin_ctrl", REG_CONVERSION_TRIGGER_PIN_CTRL, 32'h3);
		rd("alert_ctrl", REG_ALERT_CTRL, 32'h0);
		rd("alert_threshold_reg", REG_ALERT_THRESHOLD_REG, 32'hFFF);
		rd("irq_mask", REG_IRQ_MASK, 32'h0);
		rd("unmapped", 8'h20, 32'h0);
		rd("status", REG_STATUS, 32'h3D00);
		// ==========================================================
		// Channel selection, readback hold and interrupts
		wb(1'b1, REG_IRQ_MASK, 32'h7);
		foreach (modes[i])
		begin
			m = modes[i];
			cur_v <= 12'h100 + 12'(i);
			volt_v <= 12'h200 + 12'(i);
			lat <= 8'h2 + 8'(3 * i);
			if (m[0])
				exp_cur = 12'h100 + 12'(i);
			if (m[1])
				exp_volt = 12'h200 + 12'(i);
			wb(1'b1, REG_CONVERSION_TRIGGER_PIN_CTRL, 32'(m));
			n0 = n_starts;
			trig <= 1'b1;
			tick(3);
			trig <= 1'b0;
			if (m != 2'h0)
				idle_wait();
			else
				tick(30);
			chk("starts", n_starts - n0, 32'(m[0]) + 32'(m[1]));
			chk("irq_level", irq, 32'(m != 2'h0));
			rd("irq_stat", REG_IRQ_STAT, 32'(m));
			rd("current", REG_CURRENT, 32'(exp_cur));
			rd("voltage", REG_VOLTAGE, 32'(exp_volt));
			chk("irq_clear", irq, 32'h0);
		end
		// ==========================================================
		// Continuous conversions while the trigger stays high
		wb(1'b1, REG_CONVERSION_TRIGGER_PIN_CTRL, 32'h3);
		n0 = n_starts;
		trig <= 1'b1;
		tick(150);
		trig <= 1'b0;
		chk("running", 32'(n_starts - n0 > 6), 32'h1);
		idle_wait();
		rd("irq_stat", REG_IRQ_STAT, 32'h3);
		// ==========================================================
		// Analog threshold: one-cycle event, masking, refused clear
		wb(1'b1, REG_IRQ_MASK, 32'h3);
		ana <= 1'b1;
		tick(1);
		ana <= 1'b0;
		tick(6);
		chk("flag_pin", alert_pin, 32'h0);
		chk("flag_oe", flag_oe, 32'h1);
		chk("irq_masked", irq, 32'h0);
		rd("status", REG_STATUS, 32'h3D01);
		tick(30);
		chk("flag_pin", alert_pin, 32'h0);
		wb(1'b1, REG_IRQ_MASK, 32'h7);
		tick(3);
		chk("irq_unmasked", irq, 32'h1);
		rd("irq_stat", REG_IRQ_STAT, 32'h4);
		ana <= 1'b1;
		tick(4);
		wb(1'b1, REG_ALERT_CTRL, 32'h2);
		tick(3);
		chk("flag_pin", alert_pin, 32'h0);
		ana <= 1'b0;
		tick(4);
		wb(1'b1, REG_ALERT_CTRL, 32'h2);
		tick(3);
		chk("flag_pin", alert_pin, 32'h1);
		wb(1'b0, REG_IRQ_STAT, 32'h0);
		// ==========================================================
		// Digital threshold against the stored current result
		wb(1'b1, REG_ALERT_CTRL, 32'h1);
		wb(1'b1, REG_ALERT_THRESHOLD_REG, 32'h103);
		ana <= 1'b1;
		tick(4);
		chk("flag_pin", alert_pin, 32'h1);
		wb(1'b1, REG_ALERT_THRESHOLD_REG, 32'h102);
		tick(3);
		chk("flag_pin", alert_pin, 32'h0);
		wb(1'b1, REG_ALERT_CTRL, 32'h3);
		rd("alert_ctrl", REG_ALERT_CTRL, 32'h1);
		chk("flag_pin", alert_pin, 32'h0);
		wb(1'b1, REG_ALERT_THRESHOLD_REG, 32'h103);
		wb(1'b1, REG_ALERT_CTRL, 32'h3);
		tick(3);
		chk("flag_pin", alert_pin, 32'h1);
		ana <= 1'b0;
		wb(1'b1, REG_CURRENT, 32'hFFF);
		rd("current_ro", REG_CURRENT, 32'h103);
		wb(1'b1, 8'h20, 32'hFF);
		rd("unmapped", 8'h20, 32'h0);
		// ==========================================================
		// Lockout restarts the block and recaptures every strap state
		foreach (sns[i])
		begin
			s_lo <= sns[i];
			s_hi <= sns[3 - i];
			lock <= 1'b1;
			tick(4);
			lock <= 1'b0;
			tick(14);
			chk("slave_addr", saddr, 32'({3'h3, 2'(3 - i), 2'(i)}));
		end
		rd("alert_threshold_reg", REG_ALERT_THRESHOLD_REG, 32'hFFF);
		rd("alert_ctrl", REG_ALERT_CTRL, 32'h0);
		summarize();
	end
endmodule // conversion_trigger_and_alert_latch_tb_top
